//--- design/tpa_pkg.sv
`default_nettype none
package tpa_pkg;
	// ************************************************************
	// Register byte addresses on the register bus
	// ************************************************************
	localparam logic [11:0] OFS_CAUSE = 12'h0fd0;
	localparam logic [11:0] OFS_LATCH = 12'h0fc0;
	localparam logic [11:0] OFS_PTR_U = 12'h0fc4;
	localparam logic [11:0] OFS_PTR_H = 12'h0fc8;
	localparam logic [11:0] OFS_PTR_L = 12'h0fcc;
	// Register select codes produced by the address decoder.
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_CAUSE = 3'h1;
	localparam logic [2:0] SEL_LATCH = 3'h2;
	localparam logic [2:0] SEL_PTR_U = 3'h3;
	localparam logic [2:0] SEL_PTR_H = 3'h4;
	localparam logic [2:0] SEL_PTR_L = 3'h5;
	// ************************************************************
	// Reset-cause and write-control fields
	// ************************************************************
	localparam int RC_PRIO_EN = 7;
	localparam int RC_LONG_PROG = 6;
	localparam int RC_RST_INSTR = 4;
	localparam int RC_TIMEOUT = 3;
	localparam int RC_PWR_DOWN = 2;
	localparam int RC_POR = 1;
	localparam int RC_BROWN_OUT = 0;
	localparam logic [7:0] CAUSE_RST = 8'h1c;
	// ************************************************************
	// Pointer and memory map
	// ************************************************************
	localparam int PTR_W = 22;
	localparam logic [5:0] PTR_U_RST = 6'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [20:0] PTR_ONE = 21'h00_0001;
	// Highest internal program byte; anything above it with bit 21 clear is external.
	localparam logic [20:0] INT_TOP = 21'h00_7fff;
	// Pointer update modes on the operation port.
	localparam logic [1:0] MODE_KEEP = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_POSTDEC = 2'h2;
	localparam logic [1:0] MODE_PREINC = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PROG} tpa_state_t;
endpackage : tpa_pkg
`default_nettype wire

//--- design/tpa_table_access.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Bytes move only through the transfer latch.
// - Any byte address, no word alignment.
// - Three bytes form the 22-bit pointer.
// - Four pointer update modes per operation.
// - Auto update leaves the top bit alone.
// - Fetch updates pointer, then loads latch one cycle later.
// - Internal programming uses two-byte blocks.
// - Even store copies latch into holding register.
// - Holding register has no bus address.
// - Odd store programs latch high, holding low.
// - Programming needs voltage, enable and odd byte.
// - Even store never starts programming.
// - Programming halts execution, clocks keep running.
// - Enable bit cleared only by resets.
// - Enable bit ignored for external memory.
// - Reset or enabled flagged interrupt ends programming.
// - Disabled or unflagged source lets programming continue.
// - After interrupt ending, resume or vector by priority.
// - Interrupt flag stays set after ending.
// - Reset-instruction and time-out flag events.
// - Power-down, power-on and brown-out flag events.
module tpa_table_access
	import tpa_pkg::*;
(
	// Clock and power-on reset
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite register slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Table operations from the core
	input wire logic op_valid,
	input wire logic op_store,
	input wire logic [1:0] op_mode,
	output logic op_done,
	output logic op_busy,
	output logic [7:0] transfer_latch,
	// Program memory
	output logic mem_rd_en,
	output logic [21:0] mem_addr,
	input wire logic [7:0] mem_rd_data,
	output logic ext_wr_en,
	output logic [7:0] ext_wr_data,
	output logic prog_en,
	output logic [20:0] prog_word_addr,
	output logic [15:0] prog_data,
	// Programming control and interrupt sources
	input wire logic vpp_present,
	input wire logic [7:0] irq_enable_vec,
	input wire logic [7:0] irq_flag_vec,
	input wire logic [7:0] irq_high_prio_vec,
	input wire logic global_high_irq_enable,
	input wire logic peripheral_low_irq_enable,
	output logic exec_halt,
	output logic resume_next,
	output logic vector_high,
	output logic vector_low,
	// Reset-cause events
	input wire logic master_clear_reset,
	input wire logic reset_instr_op,
	input wire logic watchdog_clear_op,
	input wire logic sleep_op,
	input wire logic watchdog_timeout,
	input wire logic brown_out_event,
	output logic [7:0] reset_cause_control
);
	// ************************************************************
	// Decode and pointer helpers
	// ************************************************************
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		unique case (a)
			OFS_CAUSE: reg_sel = SEL_CAUSE;
			OFS_LATCH: reg_sel = SEL_LATCH;
			OFS_PTR_U: reg_sel = SEL_PTR_U;
			OFS_PTR_H: reg_sel = SEL_PTR_H;
			OFS_PTR_L: reg_sel = SEL_PTR_L;
			default: reg_sel = SEL_NONE;
		endcase
	endfunction : reg_sel

	// Only the lower 21 bits step, with full carry and wrap.
	function automatic logic [21:0] ptr_step(input logic [21:0] p,
		input logic down);
		if (down)
			ptr_step = {p[21], p[20:0] - PTR_ONE};
		else
			ptr_step = {p[21], p[20:0] + PTR_ONE};
	endfunction : ptr_step

	tpa_state_t state_q;
	logic [21:0] ptr_q;
	logic [7:0] latch_q;
	logic [7:0] hold_q;
	logic long_prog_en_q, prio_en_q, rst_instr_q, timeout_q, pwr_down_q;
	logic por_q, brown_out_q;
	logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q;
	logic [11:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic [1:0] bresp_q;
	logic arready_q, rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic done_q, busy_q, rd_en_q, ext_en_q, prog_q;
	logic [21:0] addr_q;
	logic [20:0] pword_q;
	logic [15:0] pdata_q;
	logic resume_q, vhigh_q, vlow_q;

	logic wr_fire;
	logic [2:0] wsel;
	logic [21:0] eff_addr;
	logic [21:0] next_ptr;
	logic take;
	logic is_ext;
	logic irq_hit;
	logic hi_hit;
	logic lo_hit;
	logic [7:0] rd_byte;
	logic [7:0] cause_val;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
	assign wsel = (wr_fire && wlane_q) ? reg_sel(awaddr_q) : SEL_NONE;

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			aw_got_q <= 1'b0;
			awready_q <= 1'b1;
			awaddr_q <= 12'h0000;
		end
		else if (s_axi_awvalid && awready_q)
		begin
			aw_got_q <= 1'b1;
			awready_q <= 1'b0;
			awaddr_q <= s_axi_awaddr;
		end
		else if (bvalid_q && s_axi_bready)
		begin
			aw_got_q <= 1'b0;
			awready_q <= 1'b1;
		end

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			w_got_q <= 1'b0;
			wready_q <= 1'b1;
			wbyte_q <= BYTE_RST;
			wlane_q <= 1'b0;
		end
		else if (s_axi_wvalid && wready_q)
		begin
			w_got_q <= 1'b1;
			wready_q <= 1'b0;
			wbyte_q <= s_axi_wdata[7:0];
			wlane_q <= s_axi_wstrb[0];
		end
		else if (bvalid_q && s_axi_bready)
		begin
			w_got_q <= 1'b0;
			wready_q <= 1'b1;
		end

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= (reg_sel(awaddr_q) == SEL_NONE) ? RESP_SLVERR
				: RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;

	assign cause_val = {prio_en_q, long_prog_en_q, 1'b0, rst_instr_q,
		timeout_q, pwr_down_q, por_q, brown_out_q};

	// The holding register is deliberately absent from this mux.
	always_comb
	begin
		unique case (reg_sel(s_axi_araddr))
			SEL_CAUSE: rd_byte = cause_val;
			SEL_LATCH: rd_byte = latch_q;
			SEL_PTR_U: rd_byte = {2'h0, ptr_q[21:16]};
			SEL_PTR_H: rd_byte = ptr_q[15:8];
			SEL_PTR_L: rd_byte = ptr_q[7:0];
			default: rd_byte = BYTE_RST;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_byte};
			rresp_q <= (reg_sel(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR
				: RESP_OKAY;
		end
		else if (rvalid_q && s_axi_rready)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end

	// ************************************************************
	// Reset-cause and write-control register
	// ************************************************************
	// A hardware event in the same cycle as a software write wins.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			long_prog_en_q <= CAUSE_RST[RC_LONG_PROG];
		else if (master_clear_reset)
			long_prog_en_q <= 1'b0;
		else if (wsel == SEL_CAUSE && wbyte_q[RC_LONG_PROG])
			long_prog_en_q <= 1'b1;

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			prio_en_q <= CAUSE_RST[RC_PRIO_EN];
			rst_instr_q <= CAUSE_RST[RC_RST_INSTR];
			timeout_q <= CAUSE_RST[RC_TIMEOUT];
			pwr_down_q <= CAUSE_RST[RC_PWR_DOWN];
			por_q <= CAUSE_RST[RC_POR];
			brown_out_q <= CAUSE_RST[RC_BROWN_OUT];
		end
		else
		begin
			if (wsel == SEL_CAUSE)
			begin
				prio_en_q <= wbyte_q[RC_PRIO_EN];
				rst_instr_q <= wbyte_q[RC_RST_INSTR];
				timeout_q <= wbyte_q[RC_TIMEOUT];
				pwr_down_q <= wbyte_q[RC_PWR_DOWN];
				por_q <= wbyte_q[RC_POR];
				brown_out_q <= wbyte_q[RC_BROWN_OUT];
			end
			if (reset_instr_op)
				rst_instr_q <= 1'b0;
			if (watchdog_timeout)
				timeout_q <= 1'b0;
			else if (watchdog_clear_op || sleep_op)
				timeout_q <= 1'b1;
			if (sleep_op)
				pwr_down_q <= 1'b0;
			else if (watchdog_clear_op)
				pwr_down_q <= 1'b1;
			if (brown_out_event)
				brown_out_q <= 1'b0;
		end

	// ************************************************************
	// Table operation engine
	// ************************************************************
	assign take = (state_q == ST_IDLE) && op_valid;
	assign eff_addr = (op_mode == MODE_PREINC) ? ptr_step(ptr_q, 1'b0)
		: ptr_q;
	assign next_ptr = (op_mode == MODE_KEEP) ? ptr_q
		: ptr_step(ptr_q, op_mode == MODE_POSTDEC);
	assign is_ext = !eff_addr[21] && (eff_addr[20:0] > INT_TOP);
	// Only the enabled sources count; flags are observed, never cleared.
	assign irq_hit = |(irq_enable_vec & irq_flag_vec);
	assign hi_hit = |(irq_enable_vec & irq_flag_vec & irq_high_prio_vec);
	assign lo_hit = |(irq_enable_vec & irq_flag_vec & ~irq_high_prio_vec);

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			state_q <= ST_IDLE;
			ptr_q <= {PTR_U_RST, BYTE_RST, BYTE_RST};
			latch_q <= BYTE_RST;
			hold_q <= BYTE_RST;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			rd_en_q <= 1'b0;
			ext_en_q <= 1'b0;
			prog_q <= 1'b0;
			addr_q <= {PTR_U_RST, BYTE_RST, BYTE_RST};
			pword_q <= 21'h00_0000;
			pdata_q <= 16'h0000;
			resume_q <= 1'b0;
			vhigh_q <= 1'b0;
			vlow_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			rd_en_q <= 1'b0;
			ext_en_q <= 1'b0;
			resume_q <= 1'b0;
			vhigh_q <= 1'b0;
			vlow_q <= 1'b0;
			unique case (state_q)
				ST_IDLE:
					if (op_valid)
					begin
						ptr_q <= next_ptr;
						addr_q <= eff_addr;
						if (!op_store)
						begin
							rd_en_q <= 1'b1;
							busy_q <= 1'b1;
							state_q <= ST_FETCH;
						end
						else if (is_ext)
						begin
							ext_en_q <= 1'b1;
							done_q <= 1'b1;
						end
						else if (!eff_addr[0])
						begin
							hold_q <= latch_q;
							done_q <= 1'b1;
						end
						else if (long_prog_en_q && vpp_present)
						begin
							prog_q <= 1'b1;
							pword_q <= eff_addr[21:1];
							pdata_q <= {latch_q, hold_q};
							busy_q <= 1'b1;
							state_q <= ST_PROG;
						end
						else
							done_q <= 1'b1;
					end
				ST_FETCH:
				begin
					latch_q <= mem_rd_data;
					done_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				ST_PROG:
					if (irq_hit || master_clear_reset)
					begin
						prog_q <= 1'b0;
						done_q <= 1'b1;
						busy_q <= 1'b0;
						state_q <= ST_IDLE;
						if (master_clear_reset)
							resume_q <= 1'b0;
						else if (hi_hit && global_high_irq_enable)
							vhigh_q <= 1'b1;
						else if (lo_hit && peripheral_low_irq_enable)
							vlow_q <= 1'b1;
						else
							resume_q <= 1'b1;
					end
			endcase
			// Bus writes to the latch or pointer dominate auto updates.
			if (wsel == SEL_LATCH)
				latch_q <= wbyte_q;
			if (wsel == SEL_PTR_U)
				ptr_q[21:16] <= wbyte_q[5:0];
			if (wsel == SEL_PTR_H)
				ptr_q[15:8] <= wbyte_q;
			if (wsel == SEL_PTR_L)
				ptr_q[7:0] <= wbyte_q;
		end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign op_done = done_q;
	assign op_busy = busy_q;
	assign transfer_latch = latch_q;
	assign mem_rd_en = rd_en_q;
	assign mem_addr = addr_q;
	assign ext_wr_en = ext_en_q;
	assign ext_wr_data = latch_q;
	assign prog_en = prog_q;
	assign exec_halt = prog_q;
	assign prog_word_addr = pword_q;
	assign prog_data = pdata_q;
	assign resume_next = resume_q;
	assign vector_high = vhigh_q;
	assign vector_low = vlow_q;
	assign reset_cause_control = cause_val;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_prog_gate: assert property ($rose(prog_q) |->
		$past(long_prog_en_q && vpp_present && take && op_store)
		&& $past(eff_addr[0] && !is_ext))
		else $error("programming started without its conditions");
	a_even_short: assert property (take && op_store && !eff_addr[0]
		&& !is_ext |=> !prog_q && hold_q == $past(latch_q))
		else $error("even store did not stay short");
	a_prog_data: assert property ($rose(prog_q) |->
		pdata_q == {$past(latch_q), $past(hold_q)})
		else $error("programmed word has wrong byte order");
	a_prog_hold: assert property (prog_q && !irq_hit
		&& !master_clear_reset |=> prog_q && exec_halt)
		else $error("programming ended without cause");
	a_irq_end: assert property (state_q == ST_PROG && irq_hit
		&& !master_clear_reset
		|=> !prog_q && done_q && (resume_q || vhigh_q || vlow_q))
		else $error("enabled flagged source did not end programming");
	a_enable_sticky: assert property ($past(long_prog_en_q)
		&& !$past(master_clear_reset) |-> long_prog_en_q)
		else $error("enable bit cleared by software");
	a_top_bit: assert property (take && wsel == SEL_NONE
		|=> ptr_q[21] == $past(ptr_q[21]))
		else $error("auto update changed pointer top bit");
	a_post_dec: assert property (take && op_mode == MODE_POSTDEC
		&& wsel == SEL_NONE |=> ptr_q[20:0] == $past(ptr_q[20:0]) - PTR_ONE)
		else $error("post-decrement wrong");
	a_fetch: assert property (take && !op_store ##1 wsel != SEL_LATCH
		|=> latch_q == $past(mem_rd_data) && $past(mem_rd_en)
		&& $past(mem_addr) == $past(eff_addr, 2))
		else $error("fetched byte not in latch");
	a_wdt_to: assert property (watchdog_timeout |=> !timeout_q)
		else $error("time-out flag not cleared");
	a_sleep_pd: assert property (sleep_op |=> !pwr_down_q && timeout_q)
		else $error("sleep did not update flags");

	c_fetch: cover property (take && !op_store ##2 done_q);
	c_prog_high: cover property ($rose(prog_q) ##[1:50] vhigh_q);
	c_prog_next: cover property ($rose(prog_q) ##[1:50] resume_q);
	c_wrap: cover property (take && op_mode == MODE_POSTINC
		&& ptr_q[20:0] == 21'h1f_ffff);
endmodule : tpa_table_access
`default_nettype wire

//--- dv/tpa_prog_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Program memory behind the table access block
// ************************************************************
module tpa_prog_mem_model
(
	// Clock
	input wire logic clk_sys,
	// Fetch and external store
	input wire logic mem_rd_en,
	input wire logic [21:0] mem_addr,
	output logic [7:0] mem_rd_data,
	input wire logic ext_wr_en,
	input wire logic [7:0] ext_wr_data,
	// Long write
	input wire logic prog_en,
	input wire logic [20:0] prog_word_addr,
	input wire logic [15:0] prog_data
);
	// Only the low address byte is decoded, so upper pages alias.
	logic [7:0] mem_q [256];
	logic [7:0] last_q;

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem_q[i] = 8'(i) ^ 8'h5a;
		last_q = 8'h00;
	end

	// Outside a fetch the bus toggles, so a stale byte is never seen.
	assign mem_rd_data = mem_rd_en ? mem_q[mem_addr[7:0]] : ~last_q;

	always @(posedge clk_sys)
	begin
		last_q <= mem_rd_data;
		if (ext_wr_en)
			mem_q[mem_addr[7:0]] <= ext_wr_data;
		if (prog_en)
		begin
			mem_q[{prog_word_addr[6:0], 1'b0}] <= prog_data[7:0];
			mem_q[{prog_word_addr[6:0], 1'b1}] <= prog_data[15:8];
		end
	end
endmodule : tpa_prog_mem_model
`default_nettype wire

//--- dv/tpa_table_access_test.sv
`timescale 1ns/10ps
`default_nettype none
module tpa_table_access_test
	import tpa_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic op_valid = 1'b0, op_store = 1'b0, op_done, op_busy;
	logic [1:0] op_mode = '0;
	logic [7:0] transfer_latch, mem_rd_data, ext_wr_data;
	logic [7:0] reset_cause_control;
	logic mem_rd_en, ext_wr_en, prog_en, exec_halt;
	logic [21:0] mem_addr;
	logic [20:0] prog_word_addr;
	logic [15:0] prog_data;
	logic vpp_present = 1'b0, global_high_irq_enable = 1'b0;
	logic peripheral_low_irq_enable = 1'b0;
	logic [7:0] irq_enable_vec = '0, irq_flag_vec = '0;
	logic [7:0] irq_high_prio_vec = '0;
	logic resume_next, vector_high, vector_low;
	logic [5:0] evs = '0;
	int n_fail = 0, checks_done = 0, ext_n = 0, prog_n = 0, vn = 0;
	logic [31:0] rdv = '0;
	logic [1:0] rsp = '0;
	logic [2:0] vec = '0;
	logic [21:0] rda = '0;
	logic [7:0] ext_d = '0;
	logic pe_q = 1'b0;

	always #20 clk_sys = ~clk_sys;

	tpa_table_access dut_u (
		.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .op_valid, .op_store, .op_mode,
		.op_done, .op_busy, .transfer_latch, .mem_rd_en, .mem_addr,
		.mem_rd_data, .ext_wr_en, .ext_wr_data, .prog_en, .prog_word_addr,
		.prog_data, .vpp_present, .irq_enable_vec, .irq_flag_vec,
		.irq_high_prio_vec, .global_high_irq_enable,
		.peripheral_low_irq_enable, .exec_halt, .resume_next, .vector_high,
		.vector_low, .master_clear_reset(evs[0]), .reset_instr_op(evs[1]),
		.watchdog_clear_op(evs[2]), .sleep_op(evs[3]),
		.watchdog_timeout(evs[4]), .brown_out_event(evs[5]),
		.reset_cause_control
	);

	tpa_prog_mem_model mem_u (.clk_sys, .mem_rd_en, .mem_addr,
		.mem_rd_data, .ext_wr_en, .ext_wr_data, .prog_en, .prog_word_addr,
		.prog_data);

	always @(posedge clk_sys)
	begin
		pe_q <= prog_en;
		if (mem_rd_en)
			rda <= mem_addr;
		if (ext_wr_en)
		begin
			ext_n <= ext_n + 1;
			ext_d <= ext_wr_data;
		end
		if (prog_en && !pe_q)
			prog_n <= prog_n + 1;
		if (vector_high | vector_low | resume_next)
		begin
			vn <= vn + 1;
			vec <= {vector_high, vector_low, resume_next};
		end
	end

	// ************************************************************
	// Bus and check tasks
	// ************************************************************
	task automatic print_verdict();
		$display("checks %0d, errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk

	task automatic tmo();
		n_fail++;
		$display("wrong value at %0t: wait ran out", $time);
		print_verdict();
	endtask : tmo

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
			// Raised one edge late so back-to-back calls never lower and
			// raise it in one time step; no answer can come that early.
			if (n == 1)
				s_axi_bready <= 1'b1;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 20);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (s_axi_bvalid !== 1'b1)
			tmo();
	endtask : wr

	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (n == 1)
				s_axi_rready <= 1'b1;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 20);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (s_axi_rvalid !== 1'b1)
			tmo();
	endtask : rd

	task automatic setptr(input logic [21:0] p);
		wr(OFS_PTR_U, {2'h0, p[21:16]});
		wr(OFS_PTR_H, p[15:8]);
		wr(OFS_PTR_L, p[7:0]);
	endtask : setptr

	task automatic chkptr(input logic [21:0] p);
		rd(OFS_PTR_U);
		chk(rdv, 32'(p[21:16]));
		rd(OFS_PTR_H);
		chk(rdv, 32'(p[15:8]));
		rd(OFS_PTR_L);
		chk(rdv, 32'(p[7:0]));
	endtask : chkptr

	task automatic wdone(input int lim);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (op_done !== 1'b1 && n < lim);
		if (op_done !== 1'b1)
			tmo();
	endtask : wdone

	task automatic op(input logic s, input logic [1:0] m, input int lim);
		op_valid <= 1'b1;
		op_store <= s;
		op_mode <= m;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		if (lim > 0)
			wdone(lim);
		tick(1);
	endtask : op

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		rd(OFS_CAUSE);
		chk(rdv, {24'h00_0000, CAUSE_RST});
		rd(OFS_LATCH);
		chk(rdv, 32'h0000_0000);
		s_axi_wstrb <= 4'h0;
		wr(OFS_LATCH, 8'h3c);
		s_axi_wstrb <= 4'hf;
		chk(32'(rsp), 32'(RESP_OKAY));
		rd(OFS_LATCH);
		chk(rdv, 32'h0000_0000);
		rd(12'h004);
		chk({rdv[29:0], rsp}, {30'h0000_0000, RESP_SLVERR});
		wr(12'h004, 8'hff);
		chk(32'(rsp), 32'(RESP_SLVERR));
	endtask : t_reset

	task automatic t_fetch();
		logic [21:0] p, a, np;
		p = 22'h00_0105;
		setptr(p);
		for (int m = 0; m < 4; m++)
		begin
			a = (m == 3) ? p + 22'h1 : p;
			np = (m == 0) ? p : ((m == 2) ? p - 22'h1 : p + 22'h1);
			op(1'b0, 2'(m), 2);
			chk(32'(rda), 32'(a));
			chk(32'(transfer_latch), 32'(a[7:0] ^ 8'h5a));
			chkptr(np);
			p = np;
		end
		setptr(22'h3f_ffff);
		op(1'b0, MODE_POSTINC, 2);
		chkptr(22'h20_0000);
		op(1'b0, MODE_POSTDEC, 2);
		chk(32'(rda), 32'h0020_0000);
		chkptr(22'h3f_ffff);
	endtask : t_fetch

	task automatic t_long();
		logic [5:0] cs [4];
		logic [21:0] b;
		logic [7:0] d0, d1;
		cs = '{6'h19, 6'h21, 6'h12, 6'h2c};
		irq_enable_vec <= 8'h01;
		vpp_present <= 1'b1;
		setptr(22'h00_0021);
		wr(OFS_LATCH, 8'h99);
		op(1'b1, MODE_KEEP, 1);
		chk(32'(prog_n), 32'h0);
		op(1'b0, MODE_KEEP, 2);
		chk(32'(transfer_latch), 32'h7b);
		wr(OFS_CAUSE, 8'h40);
		for (int k = 0; k < 4; k++)
		begin
			b = 22'h00_0040 + 22'(4 * k);
			d0 = 8'h10 + 8'(k);
			d1 = 8'ha0 + 8'(k);
			global_high_irq_enable <= cs[k][5];
			peripheral_low_irq_enable <= cs[k][4];
			irq_high_prio_vec <= {7'h00, cs[k][3]};
			setptr(b);
			wr(OFS_LATCH, d0);
			op(1'b1, MODE_POSTINC, 1);
			chk(32'(prog_n), 32'(k));
			wr(OFS_LATCH, d1);
			op(1'b1, MODE_KEEP, 0);
			tick(3);
			chk(32'({prog_en, exec_halt}), 32'h3);
			chk(32'(op_busy), 32'h1);
			chk(32'(prog_data), {16'h0000, d1, d0});
			chk(32'(prog_word_addr), 32'(b[21:1]));
			irq_flag_vec <= 8'h02;
			tick(3);
			chk(32'(prog_en), 32'h1);
			irq_flag_vec <= 8'h03;
			wdone(3);
			tick(1);
			chk(32'(vec), 32'(cs[k][2:0]));
			chk(32'(vn), 32'(k + 1));
			chk(32'({prog_en, op_busy}), 32'h0);
			irq_flag_vec <= 8'h00;
			op(1'b0, MODE_POSTDEC, 2);
			chk(32'(transfer_latch), 32'(d1));
			op(1'b0, MODE_KEEP, 2);
			chk(32'(transfer_latch), 32'(d0));
		end
	endtask : t_long

	task automatic t_master_clear_pin();
		setptr(22'h00_8001);
		wr(OFS_LATCH, 8'h77);
		op(1'b1, MODE_KEEP, 1);
		chk(32'(ext_n), 32'h1);
		chk(32'(ext_d), 32'h77);
		chk(32'(prog_n), 32'h4);
		op(1'b0, MODE_KEEP, 2);
		chk(32'(transfer_latch), 32'h77);
		wr(OFS_CAUSE, 8'h00);
		chk(32'(reset_cause_control[RC_LONG_PROG]), 32'h1);
		setptr(22'h00_0061);
		vpp_present <= 1'b0;
		op(1'b1, MODE_KEEP, 1);
		chk(32'(prog_n), 32'h4);
		vpp_present <= 1'b1;
		op(1'b1, MODE_KEEP, 0);
		tick(3);
		chk(32'(prog_en), 32'h1);
		evs <= 6'h01;
		tick(1);
		evs <= 6'h00;
		wdone(3);
		tick(1);
		chk(32'({prog_en, reset_cause_control[RC_LONG_PROG]}), 32'h0);
		chk(32'(vn), 32'h4);
	endtask : t_master_clear_pin

	task automatic t_flags();
		logic [7:0] ex [5];
		ex = '{8'h03, 8'h0f, 8'h0b, 8'h03, 8'h02};
		wr(OFS_CAUSE, 8'h13);
		chk(32'(reset_cause_control), 32'h13);
		for (int k = 1; k < 6; k++)
		begin
			evs <= 6'(1 << k);
			tick(1);
			evs <= 6'h00;
			tick(1);
			chk(32'(reset_cause_control), 32'(ex[k - 1]));
		end
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		chk(32'(reset_cause_control), 32'(CAUSE_RST));
	endtask : t_flags

	initial
	begin
		tick(3);
		rst <= 1'b0;
		tick(1);
		t_reset();
		t_fetch();
		t_long();
		t_master_clear_pin();
		t_flags();
		print_verdict();
	end
endmodule : tpa_table_access_test
`default_nettype wire
